/* design/fsp_pkg.sv */
/*
 * shared constants, state type and pointer decode for the flash self-program sequencer.
 * assumes a 25 MHz system clock and a 64-word page in a 16k-word program flash.
 */
package fsp_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register map, byte addresses on the register bus
  localparam int AXI_ADDR_W = 8;
  localparam logic [7:0] OFS_CONTROL = 8'h00; // program_memory_control_reg
  localparam logic [7:0] OFS_STATUS = 8'h04; // sequencer status
  localparam logic [7:0] OFS_POINTER = 8'h08; // flash_address_pointer, last command
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  ////////////////////////////////////////////////////////////////////////////
  // control byte codes and fields
  localparam logic [7:0] CMD_LOAD = 8'h01; // page-buffer word load
  localparam logic [7:0] CMD_ERASE = 8'h03; // page erase
  localparam logic [7:0] CMD_WRITE = 8'h05; // page write
  localparam int DISCARD_POS = 4; // buffer_discard_bit
  localparam logic [2:0] WINDOW_CYCLES = 3'h4; // cycles to issue the store instruction
  localparam int STAT_BUSY = 0;
  localparam int STAT_ARMED = 1;
  localparam int STAT_LOADED = 2;
  localparam int STAT_EE_BUSY = 3;

  ////////////////////////////////////////////////////////////////////////////
  // pointer layout: word_in_page_field and page_address_field
  localparam int PTR_W = 16;
  localparam int WORD_LSB = 1;
  localparam int WORD_W = 6;
  localparam int PAGE_LSB = WORD_LSB + WORD_W;
  localparam int PAGE_W = 8; // page_field_top_bit is PAGE_LSB + PAGE_W - 1
  localparam int FLASH_ADDR_W = PTR_W - 1;
  localparam logic [WORD_W-1:0] LAST_WORD = 6'h3F;
  localparam logic [15:0] ERASED_WORD = 16'hFFFF;

  ////////////////////////////////////////////////////////////////////////////
  // programming time
  localparam int CLK_PERIOD_NS = 40;
  localparam int PROG_MIN_NS = 3700000;
  localparam int PROG_MAX_NS = 4500000;
  localparam int PROG_MIN_CYCLES = (PROG_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PROG_MAX_CYCLES = PROG_MAX_NS / CLK_PERIOD_NS;

  ////////////////////////////////////////////////////////////////////////////
  // sequencer states, one-hot
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_ARMED = 5'h02,
    ST_ERASE = 5'h04,
    ST_STREAM = 5'h08,
    ST_PROG = 5'h10
  } fsp_state_type;

  // word within a page
  function automatic logic [WORD_W-1:0] word_field(input logic [PTR_W-1:0] ptr);
    word_field = ptr[WORD_LSB +: WORD_W];
  endfunction : word_field

  // page within the flash
  function automatic logic [PAGE_W-1:0] page_field(input logic [PTR_W-1:0] ptr);
    page_field = ptr[PAGE_LSB +: PAGE_W];
  endfunction : page_field

endpackage : fsp_pkg

/* design/fsp_page_buffer.sv */
/*
 * temporary page buffer: one word per location, per-word valid flags.
 * assumes one writer and one asynchronous reader on the system clock.
 */
`timescale 1ns/10ps
module fsp_page_buffer (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic wr_en_in,
  input wire logic [fsp_pkg::WORD_W-1:0] wr_idx_in,
  input wire logic [15:0] wr_data_in,
  input wire logic clr_in,
  input wire logic [fsp_pkg::WORD_W-1:0] rd_idx_in,
  output logic [15:0] rd_data_out,
  output logic any_loaded_out
);

  localparam int DEPTH = 1 << fsp_pkg::WORD_W;

  logic [15:0] mem [DEPTH]; // buffer words
  logic [DEPTH-1:0] valid_reg; // word loaded since last clear

  ////////////////////////////////////////////////////////////////////////////
  // storage, any order of word addresses
  always_ff @(posedge clk_in) begin
    if (wr_en_in) begin
      mem[wr_idx_in] <= wr_data_in;
    end
  end

  // valid flags: a load in the clearing cycle survives
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      valid_reg <= '0;
    end else begin
      valid_reg <= (clr_in ? '0 : valid_reg) | (wr_en_in ? (DEPTH'(1) << wr_idx_in) : '0);
    end
  end

  // unloaded words read as erased flash
  assign rd_data_out = valid_reg[rd_idx_in] ? mem[rd_idx_in] : fsp_pkg::ERASED_WORD;
  assign any_loaded_out = |valid_reg;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  a_clear_empties : assert property (@(posedge clk_in) disable iff (rst_in)
    (clr_in && !wr_en_in) |=> !any_loaded_out)
    else $error("buffer not empty after clear");

  a_load_marks : assert property (@(posedge clk_in) disable iff (rst_in)
    wr_en_in |=> valid_reg[$past(wr_idx_in)])
    else $error("loaded word not marked valid");

endmodule : fsp_page_buffer

/* design/fsp_prog_timer.sv */
/*
 * programming timer: times one erase or write from a start pulse.
 * assumes the count lies between the least and longest programming time.
 */
`timescale 1ns/10ps
module fsp_prog_timer #(
  parameter int CYCLES = fsp_pkg::PROG_MIN_CYCLES
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic start_in,
  output logic done_out
);

  localparam int CNT_W = $clog2(CYCLES + 1);

  logic [CNT_W-1:0] count_reg; // cycles left
  logic done_reg; // end of operation pulse

  ////////////////////////////////////////////////////////////////////////////
  // down counter
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      count_reg <= '0;
    end else if (start_in) begin
      count_reg <= CNT_W'(CYCLES);
    end else if (count_reg != '0) begin
      count_reg <= count_reg - CNT_W'(1);
    end
  end

  // done pulse as the count runs out
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      done_reg <= 1'b0;
    end else begin
      done_reg <= !start_in && (count_reg == CNT_W'(1));
    end
  end

  assign done_out = done_reg;

  a_done_ends_count : assert property (@(posedge clk_in) disable iff (rst_in)
    done_out |-> (count_reg == '0) && ($past(count_reg) == CNT_W'(1)))
    else $error("timer done without full count");

endmodule : fsp_prog_timer

/* design/fsp_sequencer.sv */
/*
 * flash self-program sequencer top: control register on AXI4-Lite, store
 * instruction strobe and pointer from the core, page buffer, erase/write
 * timing, core stall and byte reads of program memory.
 * assumes core strobes and eeprom status come from logic on CLK_IN, and the
 * flash returns read data one cycle after FLASH_RADDR_OUT changes.
 */
// The AXI4-Lite interface to the registers and the register offsets were decided locally.
// What this block does
// - erase code then store within four cycles
// - stall core for whole page erase
// - load code stores data pair at word
// - clear buffer after write, discard, reset
// - eeprom write discards loaded buffer words
// - write code then store programs buffer page
// - stall core for whole page write
// - buffer fill before or after erase kept
// - buffer loads accepted in any order
// - pointer splits into word and page fields
// - byte reads use pointer bit zero
// - eeprom write blocks all programming commands
// - store instruction accepted from any address
// - pointer built from two core register bytes
// - erase and write last the programming time
`timescale 1ns/10ps
module fsp_sequencer #(
  parameter int PROG_CYCLES = fsp_pkg::PROG_MIN_CYCLES
) (
  input wire logic CLK_IN,
  input wire logic RST_IN,
  input wire logic [fsp_pkg::AXI_ADDR_W-1:0] AXI_AWADDR_IN,
  input wire logic AXI_AWVALID_IN,
  output logic AXI_AWREADY_OUT,
  input wire logic [31:0] AXI_WDATA_IN,
  input wire logic [3:0] AXI_WSTRB_IN,
  input wire logic AXI_WVALID_IN,
  output logic AXI_WREADY_OUT,
  output logic [1:0] AXI_BRESP_OUT,
  output logic AXI_BVALID_OUT,
  input wire logic AXI_BREADY_IN,
  input wire logic [fsp_pkg::AXI_ADDR_W-1:0] AXI_ARADDR_IN,
  input wire logic AXI_ARVALID_IN,
  output logic AXI_ARREADY_OUT,
  output logic [31:0] AXI_RDATA_OUT,
  output logic [1:0] AXI_RRESP_OUT,
  output logic AXI_RVALID_OUT,
  input wire logic AXI_RREADY_IN,
  input wire logic SPM_STROBE_IN,
  input wire logic LPM_REQ_IN,
  input wire logic [7:0] PTR_HIGH_IN,
  input wire logic [7:0] PTR_LOW_IN,
  input wire logic [15:0] DATA_WORD_IN,
  output logic CORE_STALL_OUT,
  output logic [7:0] LPM_DATA_OUT,
  output logic LPM_VALID_OUT,
  input wire logic EEPROM_WRITE_BUSY_IN,
  input wire logic EEPROM_WRITE_START_IN,
  output logic FLASH_ERASE_OUT,
  output logic FLASH_PROG_OUT,
  output logic [fsp_pkg::PAGE_W-1:0] FLASH_PAGE_OUT,
  output logic FLASH_WSTROBE_OUT,
  output logic [fsp_pkg::WORD_W-1:0] FLASH_WORD_OUT,
  output logic [15:0] FLASH_WDATA_OUT,
  output logic [fsp_pkg::FLASH_ADDR_W-1:0] FLASH_RADDR_OUT,
  input wire logic [15:0] FLASH_RDATA_IN
);

  ////////////////////////////////////////////////////////////////////////////
  // declarations
  fsp_pkg::fsp_state_type state_reg; // sequencer state
  fsp_pkg::fsp_state_type state_next;
  logic [7:0] cmd_reg; // armed or running command byte
  logic [2:0] window_reg; // cycles left for the store instruction
  logic [fsp_pkg::PTR_W-1:0] ptr_reg; // pointer seen at last store
  logic [fsp_pkg::PTR_W-1:0] ptr_now; // pointer from core registers
  logic [fsp_pkg::PAGE_W-1:0] page_reg; // target page
  logic [fsp_pkg::WORD_W-1:0] word_idx_reg; // stream position
  logic wr_ready_reg; // write address and data taken together
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic rd_ready_reg;
  logic rvalid_reg;
  logic [1:0] rresp_reg;
  logic [31:0] rdata_reg;
  logic [31:0] read_word; // read mux
  logic stall_reg;
  logic erase_reg;
  logic prog_reg;
  logic wstrobe_reg;
  logic [fsp_pkg::WORD_W-1:0] fword_reg;
  logic [15:0] fwdata_reg;
  logic [fsp_pkg::FLASH_ADDR_W-1:0] raddr_reg;
  logic byte_sel_reg; // high byte wanted
  logic lpm_pend_reg;
  logic [7:0] lpm_data_reg;
  logic lpm_valid_reg;
  logic wr_fire; // write handshake this edge
  logic rd_fire; // read handshake this edge
  logic ctrl_accept; // control byte taken
  logic cmd_load; // new command armed
  logic discard_wr; // buffer discard requested
  logic spm_ok; // store instruction taken
  logic buf_wr;
  logic buf_clr;
  logic [15:0] buf_rdata;
  logic buf_any;
  logic timer_start;
  logic timer_done;

  default clocking cb @(posedge CLK_IN);
  endclocking
  default disable iff (RST_IN);

  ////////////////////////////////////////////////////////////////////////////
  // helpers
  function automatic logic is_mapped(input logic [fsp_pkg::AXI_ADDR_W-1:0] addr);
    is_mapped = (addr == fsp_pkg::OFS_CONTROL) || (addr == fsp_pkg::OFS_STATUS) ||
      (addr == fsp_pkg::OFS_POINTER);
  endfunction : is_mapped

  function automatic logic is_command(input logic [7:0] code);
    is_command = (code == fsp_pkg::CMD_LOAD) || (code == fsp_pkg::CMD_ERASE) ||
      (code == fsp_pkg::CMD_WRITE);
  endfunction : is_command

  function automatic logic is_busy(input fsp_pkg::fsp_state_type st);
    is_busy = (st == fsp_pkg::ST_ERASE) || (st == fsp_pkg::ST_STREAM) || (st == fsp_pkg::ST_PROG);
  endfunction : is_busy

  ////////////////////////////////////////////////////////////////////////////
  // command decode
  assign ptr_now = {PTR_HIGH_IN, PTR_LOW_IN};
  assign wr_fire = wr_ready_reg && AXI_AWVALID_IN && AXI_WVALID_IN;
  assign rd_fire = rd_ready_reg && AXI_ARVALID_IN;
  // eeprom write and running operations lock the control byte
  assign ctrl_accept = wr_fire && (AXI_AWADDR_IN == fsp_pkg::OFS_CONTROL) && AXI_WSTRB_IN[0] &&
    !EEPROM_WRITE_BUSY_IN && !is_busy(state_reg);
  // any pc may issue the strobe, no address check
  assign spm_ok = SPM_STROBE_IN && (state_reg == fsp_pkg::ST_ARMED) &&
    !EEPROM_WRITE_BUSY_IN && !EEPROM_WRITE_START_IN;
  assign cmd_load = ctrl_accept && is_command(AXI_WDATA_IN[7:0]) && !spm_ok;
  assign discard_wr = ctrl_accept && AXI_WDATA_IN[fsp_pkg::DISCARD_POS];
  assign buf_wr = spm_ok && (cmd_reg == fsp_pkg::CMD_LOAD);
  // discard bit, finished write, eeprom write into a partly loaded buffer
  // an erase never clears the buffer, so a fill before the erase survives it
  assign buf_clr = discard_wr || ((state_reg == fsp_pkg::ST_PROG) && timer_done) ||
    (EEPROM_WRITE_START_IN && buf_any);
  assign timer_start = (spm_ok && (cmd_reg == fsp_pkg::CMD_ERASE)) ||
    ((state_reg == fsp_pkg::ST_STREAM) && (word_idx_reg == fsp_pkg::LAST_WORD));

  ////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      fsp_pkg::ST_IDLE: begin
        if (cmd_load) begin
          state_next = fsp_pkg::ST_ARMED;
        end
      end
      fsp_pkg::ST_ARMED: begin
        if (spm_ok) begin
          case (cmd_reg)
            fsp_pkg::CMD_ERASE: state_next = fsp_pkg::ST_ERASE;
            fsp_pkg::CMD_WRITE: state_next = fsp_pkg::ST_STREAM;
            default: state_next = fsp_pkg::ST_IDLE; // load done in one cycle
          endcase
        end else if (cmd_load) begin
          state_next = fsp_pkg::ST_ARMED; // rearm
        end else if (ctrl_accept || (window_reg == 3'h1)) begin
          state_next = fsp_pkg::ST_IDLE;
        end
      end
      fsp_pkg::ST_ERASE: begin
        if (timer_done) begin
          state_next = fsp_pkg::ST_IDLE;
        end
      end
      fsp_pkg::ST_STREAM: begin
        if (word_idx_reg == fsp_pkg::LAST_WORD) begin
          state_next = fsp_pkg::ST_PROG;
        end
      end
      fsp_pkg::ST_PROG: begin
        if (timer_done) begin
          state_next = fsp_pkg::ST_IDLE;
        end
      end
      default: state_next = fsp_pkg::ST_IDLE;
    endcase
  end

  // state register
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      state_reg <= fsp_pkg::ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // command byte, cleared when the sequence ends or lapses
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      cmd_reg <= 8'h00;
    end else if (cmd_load) begin
      cmd_reg <= AXI_WDATA_IN[7:0];
    end else if (state_next == fsp_pkg::ST_IDLE) begin
      cmd_reg <= 8'h00;
    end
  end

  // store-instruction window
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      window_reg <= 3'h0;
    end else if (cmd_load) begin
      window_reg <= fsp_pkg::WINDOW_CYCLES;
    end else if (state_reg == fsp_pkg::ST_ARMED && window_reg != 3'h0) begin
      window_reg <= window_reg - 3'h1;
    end
  end

  // pointer and page capture at each command, erase and write independent
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      ptr_reg <= '0;
      page_reg <= '0;
    end else if (spm_ok) begin
      ptr_reg <= ptr_now;
      page_reg <= fsp_pkg::page_field(ptr_now);
    end
  end

  // stream position through the buffer
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      word_idx_reg <= '0;
    end else if (state_reg == fsp_pkg::ST_STREAM) begin
      word_idx_reg <= word_idx_reg + fsp_pkg::WORD_W'(1);
    end else begin
      word_idx_reg <= '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // core stall and flash strobes
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      stall_reg <= 1'b0;
      erase_reg <= 1'b0;
      prog_reg <= 1'b0;
    end else begin
      stall_reg <= is_busy(state_next);
      erase_reg <= (state_next == fsp_pkg::ST_ERASE);
      prog_reg <= (state_next == fsp_pkg::ST_PROG);
    end
  end

  // buffer words handed to the flash, the last one in the first cycle of FLASH_PROG_OUT
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      wstrobe_reg <= 1'b0;
      fword_reg <= '0;
      fwdata_reg <= '0;
    end else begin
      wstrobe_reg <= (state_reg == fsp_pkg::ST_STREAM);
      fword_reg <= word_idx_reg;
      fwdata_reg <= buf_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // byte read of program memory
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      raddr_reg <= '0;
      byte_sel_reg <= 1'b0;
      lpm_pend_reg <= 1'b0;
      lpm_data_reg <= 8'h00;
      lpm_valid_reg <= 1'b0;
    end else begin
      lpm_pend_reg <= LPM_REQ_IN;
      lpm_valid_reg <= lpm_pend_reg;
      if (LPM_REQ_IN) begin
        raddr_reg <= ptr_now[fsp_pkg::PTR_W-1:1];
        byte_sel_reg <= ptr_now[0];
      end
      if (lpm_pend_reg) begin
        lpm_data_reg <= byte_sel_reg ? FLASH_RDATA_IN[15:8] : FLASH_RDATA_IN[7:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register bus: write channel, address and data taken together
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      wr_ready_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= fsp_pkg::RESP_OKAY;
    end else begin
      wr_ready_reg <= !wr_ready_reg && AXI_AWVALID_IN && AXI_WVALID_IN && !bvalid_reg;
      if (wr_fire) begin
        bvalid_reg <= 1'b1;
        bresp_reg <= is_mapped(AXI_AWADDR_IN) ? fsp_pkg::RESP_OKAY : fsp_pkg::RESP_SLVERR;
      end else if (AXI_BREADY_IN) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  // read mux, unmapped reads zero
  always_comb begin
    read_word = 32'h0000_0000;
    case (AXI_ARADDR_IN)
      fsp_pkg::OFS_CONTROL: read_word[7:0] = cmd_reg;
      fsp_pkg::OFS_STATUS: begin
        read_word[fsp_pkg::STAT_BUSY] = is_busy(state_reg);
        read_word[fsp_pkg::STAT_ARMED] = (state_reg == fsp_pkg::ST_ARMED);
        read_word[fsp_pkg::STAT_LOADED] = buf_any;
        read_word[fsp_pkg::STAT_EE_BUSY] = EEPROM_WRITE_BUSY_IN;
      end
      fsp_pkg::OFS_POINTER: read_word[fsp_pkg::PTR_W-1:0] = ptr_reg;
      default: read_word = 32'h0000_0000;
    endcase
  end

  // read channel
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      rd_ready_reg <= 1'b0;
      rvalid_reg <= 1'b0;
      rresp_reg <= fsp_pkg::RESP_OKAY;
      rdata_reg <= 32'h0000_0000;
    end else begin
      rd_ready_reg <= !rd_ready_reg && AXI_ARVALID_IN && !rvalid_reg;
      if (rd_fire) begin
        rvalid_reg <= 1'b1;
        rdata_reg <= read_word;
        rresp_reg <= is_mapped(AXI_ARADDR_IN) ? fsp_pkg::RESP_OKAY : fsp_pkg::RESP_SLVERR;
      end else if (AXI_RREADY_IN) begin
        rvalid_reg <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // submodules
  fsp_page_buffer u_buffer (
    .clk_in(CLK_IN),
    .rst_in(RST_IN),
    .wr_en_in(buf_wr),
    .wr_idx_in(fsp_pkg::word_field(ptr_now)),
    .wr_data_in(DATA_WORD_IN),
    .clr_in(buf_clr),
    .rd_idx_in(word_idx_reg),
    .rd_data_out(buf_rdata),
    .any_loaded_out(buf_any)
  );

  fsp_prog_timer #(
    .CYCLES(PROG_CYCLES)
  ) u_timer (
    .clk_in(CLK_IN),
    .rst_in(RST_IN),
    .start_in(timer_start),
    .done_out(timer_done)
  );

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  assign AXI_AWREADY_OUT = wr_ready_reg;
  assign AXI_WREADY_OUT = wr_ready_reg;
  assign AXI_BVALID_OUT = bvalid_reg;
  assign AXI_BRESP_OUT = bresp_reg;
  assign AXI_ARREADY_OUT = rd_ready_reg;
  assign AXI_RVALID_OUT = rvalid_reg;
  assign AXI_RRESP_OUT = rresp_reg;
  assign AXI_RDATA_OUT = rdata_reg;
  assign CORE_STALL_OUT = stall_reg;
  assign LPM_DATA_OUT = lpm_data_reg;
  assign LPM_VALID_OUT = lpm_valid_reg;
  assign FLASH_ERASE_OUT = erase_reg;
  assign FLASH_PROG_OUT = prog_reg;
  assign FLASH_PAGE_OUT = page_reg;
  assign FLASH_WSTROBE_OUT = wstrobe_reg;
  assign FLASH_WORD_OUT = fword_reg;
  assign FLASH_WDATA_OUT = fwdata_reg;
  assign FLASH_RADDR_OUT = raddr_reg;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  sequence s_armed_fresh;
    (state_reg == fsp_pkg::ST_ARMED) && (window_reg == fsp_pkg::WINDOW_CYCLES);
  endsequence

  sequence s_no_strobe4;
    (!SPM_STROBE_IN && !ctrl_accept)[*4];
  endsequence

  a_window_lapse : assert property (s_armed_fresh ##0 s_no_strobe4 |=>
    (state_reg == fsp_pkg::ST_IDLE) && (cmd_reg == 8'h00))
    else $error("command not dropped after window");

  a_erase_start : assert property ((spm_ok && cmd_reg == fsp_pkg::CMD_ERASE) |=>
    (state_reg == fsp_pkg::ST_ERASE) && FLASH_ERASE_OUT && CORE_STALL_OUT)
    else $error("erase did not start");

  a_stall_erase : assert property ((state_reg == fsp_pkg::ST_ERASE) |-> CORE_STALL_OUT)
    else $error("core not stalled in erase");

  a_stall_write : assert property ((state_reg == fsp_pkg::ST_PROG) |->
    CORE_STALL_OUT && FLASH_PROG_OUT)
    else $error("core not stalled in write");

  a_load_word : assert property (buf_wr |=> buf_any && !CORE_STALL_OUT &&
    (state_reg == fsp_pkg::ST_IDLE))
    else $error("load not completed");

  // helper: consecutive streaming cycles, counted apart from the stream index
  localparam int LEN_W = fsp_pkg::WORD_W + 1;
  localparam logic [LEN_W-1:0] PAGE_WORDS = LEN_W'(1 << fsp_pkg::WORD_W); // words in one page
  logic [LEN_W-1:0] stream_len_reg; // cycles spent in the stream state

  // counts up while streaming, cleared one cycle after the stream state is left
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      stream_len_reg <= '0;
    end else if (state_reg == fsp_pkg::ST_STREAM) begin
      stream_len_reg <= stream_len_reg + LEN_W'(1);
    end else begin
      stream_len_reg <= '0;
    end
  end

  a_stream_start : assert property ((spm_ok && cmd_reg == fsp_pkg::CMD_WRITE) |=>
    (state_reg == fsp_pkg::ST_STREAM) && (stream_len_reg == '0))
    else $error("page stream did not start");

  a_stream_length : assert property (((state_reg == fsp_pkg::ST_PROG) && (stream_len_reg != '0)) |->
    (stream_len_reg == PAGE_WORDS))
    else $error("page stream length wrong");

  a_eeprom_block : assert property ((EEPROM_WRITE_BUSY_IN && SPM_STROBE_IN) |=>
    !is_busy(state_reg) || is_busy($past(state_reg)))
    else $error("command taken during eeprom write");

  a_eeprom_discard : assert property ((EEPROM_WRITE_START_IN && !buf_wr) |=> !buf_any)
    else $error("buffer kept across eeprom write");

  a_write_clears : assert property (((state_reg == fsp_pkg::ST_PROG) && timer_done) |=>
    !buf_any && !CORE_STALL_OUT)
    else $error("buffer not cleared after write");

  a_erase_keeps : assert property (((state_reg == fsp_pkg::ST_ERASE) && !EEPROM_WRITE_START_IN) |=>
    $stable(buf_any))
    else $error("buffer changed by erase");

  a_byte_read : assert property (LPM_REQ_IN |-> ##2 LPM_VALID_OUT && (LPM_DATA_OUT ==
    ($past(PTR_LOW_IN[0], 2) ? $past(FLASH_RDATA_IN[15:8]) : $past(FLASH_RDATA_IN[7:0]))))
    else $error("byte read wrong");

endmodule : fsp_sequencer

/* testbench/fsp_flash_model.sv */
/* flash array model: blanks erased pages, programs streamed rows, answers reads.
   assumes the sequencer's flash port timing */
`timescale 1ns/10ps
module fsp_flash_model (
  input wire logic clk_in,
  input wire logic erase_in,
  input wire logic prog_in,
  input wire logic [7:0] page_in,
  input wire logic wstrobe_in,
  input wire logic [5:0] word_in,
  input wire logic [15:0] wdata_in,
  input wire logic [14:0] raddr_in,
  output logic [15:0] rdata_out
);
  logic [15:0] mem [0:32767]; // program words
  logic [15:0] row [0:63]; // streamed page
  // programming only clears bits, so an unerased page reads wrong
  always_ff @(posedge clk_in) begin
    for (int i = 0; i < 64; i++) begin
      if (erase_in) mem[{1'h0, page_in, 6'(i)}] <= 16'hFFFF;
      if (prog_in && !wstrobe_in) mem[{1'h0, page_in, 6'(i)}] <= mem[{1'h0, page_in, 6'(i)}] & row[i];
    end
    if (wstrobe_in) row[word_in] <= wdata_in;
  end
  assign rdata_out = mem[raddr_in]; // word ready by the next edge
endmodule : fsp_flash_model

/* testbench/fsp_sequencer_tb.sv */
/* self-checking bench for the sequencer; assumes the flash model beside it */
`timescale 1ns/10ps
module fsp_sequencer_tb;
  localparam int PC = 20; // shortened programming time
  logic CLK_IN = 0, RST_IN = 1, AXI_AWVALID_IN = 0, AXI_WVALID_IN = 0, AXI_ARVALID_IN = 0, AXI_BREADY_IN = 0;
  logic AXI_RREADY_IN = 0, SPM_STROBE_IN = 0, LPM_REQ_IN = 0, EEPROM_WRITE_BUSY_IN = 0, EEPROM_WRITE_START_IN = 0;
  logic [7:0] AXI_AWADDR_IN = 0, AXI_ARADDR_IN = 0, PTR_HIGH_IN = 0, PTR_LOW_IN = 0, LPM_DATA_OUT, FLASH_PAGE_OUT;
  logic [31:0] AXI_WDATA_IN = 0, AXI_RDATA_OUT;
  logic [3:0] AXI_WSTRB_IN = 4'hF;
  logic [1:0] AXI_BRESP_OUT, AXI_RRESP_OUT;
  logic AXI_AWREADY_OUT, AXI_WREADY_OUT, AXI_BVALID_OUT, AXI_ARREADY_OUT, AXI_RVALID_OUT, CORE_STALL_OUT;
  logic LPM_VALID_OUT, FLASH_ERASE_OUT, FLASH_PROG_OUT, FLASH_WSTROBE_OUT;
  logic [15:0] DATA_WORD_IN = 0, FLASH_WDATA_OUT, FLASH_RDATA_IN;
  logic [5:0] FLASH_WORD_OUT;
  logic [14:0] FLASH_RADDR_OUT;
  int mismatches = 0, checks = 0, n;
  fsp_sequencer #(.PROG_CYCLES(PC)) i_fsp_sequencer (.*);
  fsp_flash_model i_fsp_flash_model (.clk_in(CLK_IN), .erase_in(FLASH_ERASE_OUT), .prog_in(FLASH_PROG_OUT),
    .page_in(FLASH_PAGE_OUT), .wstrobe_in(FLASH_WSTROBE_OUT), .word_in(FLASH_WORD_OUT),
    .wdata_in(FLASH_WDATA_OUT), .raddr_in(FLASH_RADDR_OUT), .rdata_out(FLASH_RDATA_IN));
  initial forever #20 CLK_IN = ~CLK_IN;
  task automatic ck(input string nm, input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      mismatches++;
      $display("BAD %s exp %h seen %h", nm, e, s);
    end
  endtask : ck
  // register write, each channel held until its own ready
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    @(posedge CLK_IN);
    {AXI_AWADDR_IN, AXI_WDATA_IN, AXI_AWVALID_IN, AXI_WVALID_IN, AXI_BREADY_IN} <= {a, d, 3'h7};
    do begin
      @(posedge CLK_IN);
      if (AXI_AWREADY_OUT) AXI_AWVALID_IN <= 0;
      if (AXI_WREADY_OUT) AXI_WVALID_IN <= 0;
    end while (AXI_BVALID_OUT !== 1'h1);
    AXI_BREADY_IN <= 0;
    ck("bresp", AXI_BRESP_OUT, r);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
    @(posedge CLK_IN);
    {AXI_ARADDR_IN, AXI_ARVALID_IN, AXI_RREADY_IN} <= {a, 2'h3};
    do begin
      @(posedge CLK_IN);
      if (AXI_ARREADY_OUT) AXI_ARVALID_IN <= 0;
    end while (AXI_RVALID_OUT !== 1'h1);
    AXI_RREADY_IN <= 0;
    ck("rdata", AXI_RDATA_OUT, e);
    ck("rresp", AXI_RRESP_OUT, r);
  endtask : rd
  // command byte, then store strobe on page 3
  task automatic cmd(input logic [7:0] c, input logic [5:0] w, input logic [15:0] d);
    wr(8'h00, {24'h0, c}, 2'h0);
    {PTR_HIGH_IN, PTR_LOW_IN, DATA_WORD_IN, SPM_STROBE_IN} <= {9'h3, w, 1'h0, d, 1'h1};
    @(posedge CLK_IN);
    SPM_STROBE_IN <= 0;
  endtask : cmd
  task automatic busy;
    n = 0;
    do begin @(posedge CLK_IN); n++; end while (CORE_STALL_OUT === 1'h1 && n < 999);
  endtask : busy
  task automatic lpm(input logic [5:0] w, input logic b, input logic [7:0] e);
    {PTR_HIGH_IN, PTR_LOW_IN, LPM_REQ_IN} <= {9'h3, w, b, 1'h1};
    @(posedge CLK_IN);
    LPM_REQ_IN <= 0;
    do @(posedge CLK_IN); while (LPM_VALID_OUT !== 1'h1);
    ck("byte", LPM_DATA_OUT, e);
  endtask : lpm
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : end_of_test
  // watchdog
  initial begin
    repeat (20000) @(posedge CLK_IN);
    mismatches++;
    end_of_test;
  end
  // fill out of order, erase, write, read back
  task automatic t_program;
    rd(8'h04, 32'h0, 2'h0);
    rd(8'h0C, 32'h0, 2'h2);
    wr(8'h0C, 32'h1, 2'h2);
    cmd(fsp_pkg::CMD_LOAD, 6'h05, 16'hA5C3);
    cmd(fsp_pkg::CMD_LOAD, 6'h00, 16'h1234);
    cmd(fsp_pkg::CMD_LOAD, 6'h3F, 16'hBEEF);
    cmd(fsp_pkg::CMD_ERASE, 6'h00, 16'h0);
    busy;
    ck("erase stall", n, PC + 2);
    rd(8'h04, 32'h4, 2'h0);
    cmd(fsp_pkg::CMD_WRITE, 6'h00, 16'h0);
    busy;
    ck("write stall", n, PC + 66);
    rd(8'h04, 32'h0, 2'h0);
    lpm(6'h05, 0, 8'hC3);
    lpm(6'h05, 1, 8'hA5);
    lpm(6'h00, 1, 8'h12);
    lpm(6'h3F, 0, 8'hEF);
    lpm(6'h01, 0, 8'hFF);
    $display("test program done");
  endtask : t_program
  // lapse, eeprom interlock, discard
  task automatic t_guards;
    wr(8'h00, {24'h0, fsp_pkg::CMD_ERASE}, 2'h0);
    repeat (4) @(posedge CLK_IN);
    rd(8'h00, 32'h0, 2'h0);
    cmd(8'h00, 6'h00, 16'h0);
    rd(8'h04, 32'h0, 2'h0);
    EEPROM_WRITE_BUSY_IN <= 1;
    cmd(fsp_pkg::CMD_LOAD, 6'h02, 16'h0);
    rd(8'h04, 32'h8, 2'h0);
    EEPROM_WRITE_BUSY_IN <= 0;
    cmd(fsp_pkg::CMD_LOAD, 6'h02, 16'h0);
    EEPROM_WRITE_START_IN <= 1;
    @(posedge CLK_IN);
    EEPROM_WRITE_START_IN <= 0;
    rd(8'h04, 32'h0, 2'h0);
    cmd(fsp_pkg::CMD_LOAD, 6'h02, 16'h0);
    wr(8'h00, 32'h10, 2'h0);
    rd(8'h04, 32'h0, 2'h0);
    $display("test guards done");
  endtask : t_guards
  initial begin
    repeat (3) @(posedge CLK_IN);
    RST_IN <= 0;
    t_program;
    t_guards;
    end_of_test;
  end
endmodule : fsp_sequencer_tb
